// [rtl/msx_exec.sv]
/*
 * Execution unit for nibble swap, zero skips, table reads and XOR.
 * Assumes the data memory byte at ins.addr is presented combinationally
 * on dm_rdata in the cycle the instruction is issued, and that program
 * memory answers a read combinationally in the cycle pm_addr is driven.
 */
// Function
// - Swap exchanges the two nibbles of the byte in place, no flags change.
// - Swap-to-register puts the swapped byte in the work register only.
// - Skip-when-zero takes two cycles with a discard if the byte is zero.
// - Copy-and-skip loads the work register and skips likewise on zero.
// - Current-page table read splits the word to memory and high latch.
// - Last-page table read does the same from the last program page.
// - Register XOR memory goes to the work register, zero flag only.
// - Memory XOR register goes back to memory, zero flag only.
// - Immediate XOR goes to the work register, zero flag only.
module msx_exec
  import msx_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ins_valid,
  input wire msx_ins_t ins,
  output logic ins_ready,
  input wire logic [7:0] dm_rdata,
  output msx_dm_wr_t dm_wr,
  input wire logic [TP_W-1:0] table_read_pointer,
  input wire logic [PAGE_W-1:0] cur_page,
  output logic [PM_AW-1:0] pm_addr,
  input wire logic [PM_DW-1:0] pm_rdata,
  output logic [7:0] work_register,
  output logic zero_flag,
  output logic [TH_W-1:0] table_high_latch,
  output logic discard_next
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_TABLE
  } msx_state_t;

  msx_state_t state_ff, nxt_state;
  logic [7:0] wreg_ff, nxt_wreg;
  logic zf_ff, nxt_zf;
  logic [TH_W-1:0] th_ff, nxt_th;
  logic [PM_AW-1:0] pma_ff, nxt_pma;
  logic [DM_AW-1:0] dest_ff, nxt_dest;
  msx_dm_wr_t wr_ff, nxt_wr;
  logic disc_ff, nxt_disc;

  wire logic issue = ins_valid && (state_ff == ST_IDLE);

  // Op decode shared by the skip and table paths
  wire logic op_skip_byte = (ins.op == OP_SKIP_ZERO);
  wire logic op_copy_skip = (ins.op == OP_COPY_SKIP_ZERO);
  wire logic op_skip_bit = (ins.op == OP_SKIP_BIT_ZERO);
  wire logic op_tbl_last = (ins.op == OP_TBL_LAST);

  wire logic [7:0] swapped = {dm_rdata[3:0], dm_rdata[7:4]};
  wire logic [7:0] xor_mem = wreg_ff ^ dm_rdata;
  wire logic [7:0] xor_imm = wreg_ff ^ ins.imm;
  wire logic byte_zero = (dm_rdata == 8'h00);
  wire logic bit_clear = ~dm_rdata[ins.bit_sel];
  wire logic zf_mem = (xor_mem == 8'h00);
  wire logic zf_imm = (xor_imm == 8'h00);
  wire logic [PAGE_W-1:0] tbl_page =
    op_tbl_last ? LAST_PAGE : cur_page;
  wire logic [PM_AW-1:0] tbl_addr = {tbl_page, table_read_pointer};

  // Skip decision: the instruction already fetched behind us is dropped
  wire logic take_skip =
    (op_skip_byte && byte_zero) ||
    (op_copy_skip && byte_zero) ||
    (op_skip_bit && bit_clear);

  assign ins_ready = (state_ff == ST_IDLE);
  // Writes land a cycle late; a following instruction on the same byte
  // reads the old value unless the memory forwards it
  assign dm_wr = wr_ff;
  assign pm_addr = pma_ff;
  assign work_register = wreg_ff;
  assign zero_flag = zf_ff;
  assign table_high_latch = th_ff;
  assign discard_next = disc_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_wreg = wreg_ff;
    nxt_zf = zf_ff;
    nxt_th = th_ff;
    nxt_pma = pma_ff;
    nxt_dest = dest_ff;
    nxt_wr = '0;
    nxt_disc = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (issue) begin
          case (ins.op)
            OP_SWAP_MEM: begin
              nxt_wr = '{we: 1'b1, addr: ins.addr, data: swapped};
            end
            OP_SWAP_WREG: begin
              nxt_wreg = swapped;
            end
            OP_SKIP_ZERO, OP_SKIP_BIT_ZERO: begin
              if (take_skip) begin
                nxt_disc = 1'b1;
                nxt_state = ST_DUMMY;
              end
            end
            OP_COPY_SKIP_ZERO: begin
              nxt_wreg = dm_rdata;
              if (take_skip) begin
                nxt_disc = 1'b1;
                nxt_state = ST_DUMMY;
              end
            end
            OP_TBL_CUR, OP_TBL_LAST: begin
              nxt_pma = tbl_addr;
              nxt_dest = ins.addr;
              nxt_state = ST_TABLE;
            end
            OP_XOR_WREG: begin
              nxt_wreg = xor_mem;
              nxt_zf = zf_mem;
            end
            OP_XOR_MEM: begin
              nxt_wr = '{we: 1'b1, addr: ins.addr, data: xor_mem};
              nxt_zf = zf_mem;
            end
            OP_XOR_IMM: begin
              nxt_wreg = xor_imm;
              nxt_zf = zf_imm;
            end
            default: begin
            end
          endcase
        end
      end
      ST_DUMMY: begin
        // Dummy cycle fills the slot of the discarded instruction
        nxt_state = ST_IDLE;
      end
      ST_TABLE: begin
        // Program word arrives now; low byte to memory, rest to the latch
        nxt_wr = '{we: 1'b1, addr: dest_ff,
                   data: pm_rdata[LOW_MSB:0]};
        nxt_th = pm_rdata[PM_DW-1:HIGH_LSB];
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wreg_ff <= WREG_RST;
    end else begin
      wreg_ff <= nxt_wreg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zf_ff <= ZF_RST;
    end else begin
      zf_ff <= nxt_zf;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      th_ff <= TH_RST;
    end else begin
      th_ff <= nxt_th;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pma_ff <= '0;
    end else begin
      pma_ff <= nxt_pma;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dest_ff <= '0;
    end else begin
      dest_ff <= nxt_dest;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      disc_ff <= 1'b0;
    end else begin
      disc_ff <= nxt_disc;
    end
  end

endmodule : msx_exec

// [rtl/msx_pkg.sv]
/*
 * Shared constants and types for the swap, skip, table-read and XOR
 * execution unit. Assumes a core with a 14-bit program word, 512 words of
 * program memory in 256-word pages and 8-bit data memory.
 */
package msx_pkg;

  localparam int DM_AW = 7;
  localparam int PM_AW = 9;
  localparam int PM_DW = 14;
  localparam int TP_W = 8;
  localparam int PAGE_W = PM_AW - TP_W;
  localparam int TH_W = PM_DW - 8;

  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic ZF_RST = 1'b0;
  localparam logic [TH_W-1:0] TH_RST = 6'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE = '1;

  // Low byte of a program word, high part above it
  localparam int LOW_MSB = 7;
  localparam int HIGH_LSB = 8;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_SWAP_MEM,
    OP_SWAP_WREG,
    OP_SKIP_ZERO,
    OP_COPY_SKIP_ZERO,
    OP_SKIP_BIT_ZERO,
    OP_TBL_CUR,
    OP_TBL_LAST,
    OP_XOR_WREG,
    OP_XOR_MEM,
    OP_XOR_IMM
  } msx_op_t;

  typedef struct packed {
    msx_op_t op;
    logic [DM_AW-1:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } msx_ins_t;

  typedef struct packed {
    logic we;
    logic [DM_AW-1:0] addr;
    logic [7:0] data;
  } msx_dm_wr_t;

endpackage : msx_pkg

// [testbench/msx_exec_asserts.sv]
/* Port assertions for msx_exec.
   Bound onto msx_exec from tb. */
module msx_chk
  import msx_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ins_valid,
  input wire msx_ins_t ins,
  input wire logic ins_ready,
  input wire logic [7:0] dm_rdata,
  input wire msx_dm_wr_t dm_wr,
  input wire logic [TP_W-1:0] table_read_pointer,
  input wire logic [PAGE_W-1:0] cur_page,
  input wire logic [PM_AW-1:0] pm_addr,
  input wire logic [PM_DW-1:0] pm_rdata,
  input wire logic [7:0] work_register,
  input wire logic zero_flag,
  input wire logic [TH_W-1:0] table_high_latch,
  input wire logic discard_next
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire [7:0] swp = {dm_rdata[3:0], dm_rdata[7:4]};
  wire bit_v = dm_rdata[ins.bit_sel];
  wire tbl = ins.op == OP_TBL_CUR || ins.op == OP_TBL_LAST;
  wire [PAGE_W-1:0] pg = ins.op == OP_TBL_LAST ? LAST_PAGE : cur_page;
  wire [7:0] lo = pm_rdata[7:0];
  wire [TH_W-1:0] hi = pm_rdata[PM_DW-1:8];
  sequence took(msx_op_t o);
    ins_valid && ins_ready && ins.op == o;
  endsequence
  sequence tbl_addr;
    pm_addr == {$past(pg), $past(table_read_pointer)};
  endsequence
  sequence tbl_fill;
    dm_wr.we && dm_wr.data == $past(lo) && table_high_latch == $past(hi);
  endsequence
  a_swap_mem: assert property (took(OP_SWAP_MEM) |=> dm_wr.we &&
    dm_wr.data == $past(swp) && $stable(zero_flag)) else $error("swap");
  a_swap_reg: assert property (took(OP_SWAP_WREG) |=>
    work_register == $past(swp) && !dm_wr.we) else $error("swap reg");
  a_skip_zero: assert property (took(OP_SKIP_ZERO) |=>
    discard_next == ($past(dm_rdata) == 8'h00)) else $error("skip");
  a_copy_skip: assert property (took(OP_COPY_SKIP_ZERO) |=>
    work_register == $past(dm_rdata) &&
    discard_next == (work_register == 8'h00)) else $error("copy skip");
  a_bit_skip: assert property (took(OP_SKIP_BIT_ZERO) |=>
    discard_next == !$past(bit_v)) else $error("bit skip");
  a_table_read: assert property (ins_valid && ins_ready && tbl |=>
    tbl_addr ##1 tbl_fill) else $error("table read");
  a_xor_mem: assert property (took(OP_XOR_MEM) |=>
    dm_wr.data == ($past(work_register) ^ $past(dm_rdata)) &&
    zero_flag == (dm_wr.data == 8'h00)) else $error("xor mem");
  a_xor_imm: assert property (took(OP_XOR_IMM) |=>
    work_register == ($past(work_register) ^ $past(ins.imm)) &&
    zero_flag == (work_register == 8'h00)) else $error("xor imm");
  a_xor_reg: assert property (took(OP_XOR_WREG) |=>
    work_register == ($past(work_register) ^ $past(dm_rdata)) &&
    zero_flag == (work_register == 8'h00)) else $error("xor reg");
  a_skip_busy: assert property (discard_next |-> !ins_ready)
    else $error("skip busy");
endmodule : msx_chk

// [testbench/msx_mem.sv]
/* Data and program memory facing msx_exec.
   The bench fills both arrays. */
module msx_mem
  import msx_pkg::*;
(
  input wire logic clock,
  input wire msx_ins_t ins,
  output logic [7:0] dm_rdata,
  input wire msx_dm_wr_t dm_wr,
  input wire logic [PM_AW-1:0] pm_addr,
  output logic [PM_DW-1:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dmem [2**DM_AW];
  logic [PM_DW-1:0] prog [2**PM_AW];
  assign dm_rdata = dmem[ins.addr];
  // Word settles long before the edge that takes it
  assign pm_rdata = prog[pm_addr];
  always @(posedge clock)
    if (dm_wr.we) dmem[dm_wr.addr] <= dm_wr.data;
endmodule : msx_mem

// [testbench/tb.sv]
/* Each op in turn with random operands, checked against a bench model.
   Needs msx_pkg, msx_mem and msx_chk. */
module tb
  import msx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, arst_n = 0, ins_valid = 0;
  logic [PAGE_W-1:0] cur_page = '0;
  logic [TP_W-1:0] table_read_pointer = '0;
  msx_ins_t ins = '0;
  logic [7:0] dm_rdata, work_register;
  msx_dm_wr_t dm_wr;
  logic [PM_AW-1:0] pm_addr;
  logic [PM_DW-1:0] pm_rdata;
  logic [TH_W-1:0] table_high_latch;
  logic ins_ready, zero_flag, discard_next;
  int fails = 0, checks_done = 0, cyc = 0, seed = 99967, w = 0, z = 0;
  always #12.5 clock = ~clock;
  msx_exec msx_exec_inst(
    .clock(clock), .arst_n(arst_n), .ins_valid(ins_valid), .ins(ins),
    .ins_ready(ins_ready), .dm_rdata(dm_rdata), .dm_wr(dm_wr),
    .table_read_pointer(table_read_pointer), .cur_page(cur_page),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .work_register(work_register),
    .zero_flag(zero_flag), .table_high_latch(table_high_latch),
    .discard_next(discard_next));
  msx_mem msx_mem_inst(
    .clock(clock), .ins(ins), .dm_rdata(dm_rdata), .dm_wr(dm_wr),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Three or four cycles per instruction, so this leaves ample margin
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  task automatic run(msx_op_t op);
    logic [31:0] k;
    logic [7:0] b, r;
    logic [PM_DW-1:0] pw;
    logic d, we, t;
    @(posedge clock);
    #1;
    k = $random(seed);
    t = op == OP_TBL_CUR || op == OP_TBL_LAST;
    // Force zero bytes and zero results often enough to matter
    if (k[0]) msx_mem_inst.dmem[k[14:8]] = k[1] ? 8'h00 : w[7:0];
    b = msx_mem_inst.dmem[k[14:8]];
    pw = msx_mem_inst.prog[{op == OP_TBL_LAST ? LAST_PAGE : k[2], k[23:16]}];
    d = 0;
    we = 0;
    r = pw[7:0];
    case (op)
      OP_SWAP_MEM: begin we = 1; r = {b[3:0], b[7:4]}; end
      OP_SWAP_WREG: w = {b[3:0], b[7:4]};
      OP_SKIP_ZERO: d = b == 0;
      OP_COPY_SKIP_ZERO: begin w = b; d = b == 0; end
      OP_SKIP_BIT_ZERO: d = !b[k[6:4]];
      OP_XOR_WREG: begin w ^= b; z = w == 0; end
      OP_XOR_MEM: begin we = 1; r = w ^ b; z = r == 0; end
      OP_XOR_IMM: begin w ^= k[31:24]; z = w == 0; end
      default: ;
    endcase
    @(posedge clock);
    ins_valid <= 1;
    ins <= '{op, k[14:8], k[6:4], k[31:24]};
    table_read_pointer <= k[23:16];
    cur_page <= k[2];
    @(posedge clock);
    ins_valid <= 0;
    #1;
    chk(work_register, w[7:0]);
    chk(zero_flag, z[0]);
    chk({dm_wr.we, discard_next, ins_ready}, {we, d, !(d || t)});
    if (we) chk({dm_wr.addr, dm_wr.data}, {k[14:8], r});
    if (t) begin
      chk(pm_addr, {op == OP_TBL_LAST ? LAST_PAGE : k[2], k[23:16]});
      @(posedge clock);
      #1;
      chk({dm_wr.we, ins_ready}, 2'h3);
      chk({dm_wr.addr, dm_wr.data}, {k[14:8], r});
      chk(table_high_latch, pw[PM_DW-1:8]);
    end
  endtask : run
  initial begin
    foreach (msx_mem_inst.dmem[i]) msx_mem_inst.dmem[i] = $random(seed);
    foreach (msx_mem_inst.prog[i]) msx_mem_inst.prog[i] = $random(seed);
    repeat (2) @(posedge clock);
    arst_n <= 1;
    #1;
    chk({work_register, zero_flag, discard_next, ins_ready}, 16'h0001);
    chk(dm_wr, 16'h0000);
    chk({pm_addr, table_high_latch}, 16'h0000);
    for (int i = 0; i < 330; i++) run(msx_op_t'(i % 11));
    complete_run();
  end
endmodule : tb
bind msx_exec msx_chk msx_chk_inst(
  .clock(clock), .arst_n(arst_n), .ins_valid(ins_valid), .ins(ins),
  .ins_ready(ins_ready), .dm_rdata(dm_rdata), .dm_wr(dm_wr),
  .table_read_pointer(table_read_pointer), .cur_page(cur_page),
  .pm_addr(pm_addr), .pm_rdata(pm_rdata), .work_register(work_register),
  .zero_flag(zero_flag), .table_high_latch(table_high_latch),
  .discard_next(discard_next));
